// ==== core_sfr_defs.svh ====
`ifndef CORE_SFR_DEFS_SVH
`define CORE_SFR_DEFS_SVH

// Register offsets within the low sixteen addresses of the bank
`define SFR_OFS_INDIRECT 4'h0
`define SFR_OFS_STATUS 4'h3
`define SFR_OFS_POINTER 4'h4
`define SFR_OFS_PORT 4'h6
`define SFR_OFS_POWER 4'h8
`define SFR_OFS_WAKEUP 4'h9
`define SFR_OFS_COUNTER_HIGH_BUFFER 4'hA
`define SFR_OFS_PULLDOWN 4'hB
`define SFR_OFS_PULLUP 4'hC
`define SFR_OFS_IRQ_EN 4'hE

// Reset values
`define SFR_RST_STATUS 8'h18
`define SFR_RST_POINTER 8'h00
`define SFR_RST_PORT 8'h00
`define SFR_RST_POWER 8'h88
`define SFR_RST_WAKEUP 8'h3F
`define SFR_RST_COUNTER_HIGH_BUFFER 8'h00
`define SFR_RST_PULLDOWN 8'hFF
`define SFR_RST_PULLUP 8'h3F
`define SFR_RST_IRQ_EN 8'h00

// Writable bit masks; other bits ignore writes
`define SFR_MASK_WAKEUP 8'h3F
`define SFR_MASK_COUNTER_HIGH_BUFFER 8'h07
`define SFR_MASK_PULLDOWN 8'hF0
`define SFR_MASK_PULLUP 8'h3F
`define SFR_MASK_IRQ_EN 8'h4F
// Reserved low nibble of the pull-down register reads as ones
`define SFR_FILL_PULLDOWN 8'h0F

// Status bit positions
`define ST_CARRY 0
`define ST_HALF_CARRY 1
`define ST_ZERO 2
`define ST_POWER_DOWN_N 3
`define ST_TIMEOUT_N 4

// Power control bit positions
`define PWR_LVR_EN 3
`define PWR_EXT_IRQ_SEL 6
`define PWR_WDT_EN 7

// Interrupt enable bit position
`define IRQ_TIMER0 0

// Port geometry
`define PORT_PINS 6
`define PULLDOWN_PINS 4
`define PULLDOWN_LSB 4

`endif

// ==== core_sfr_pkg.sv ====
package core_sfr_pkg;

	typedef enum logic [1:0] {
		ALU_ADD,
		ALU_SUB,
		ALU_LOGIC
	} alu_kind_type;

endpackage

// ==== sfr_link_if.sv ====
`timescale 1ns/1ps
interface sfr_link_if;
	core_sfr_pkg::alu_kind_type alu_kind;
	logic [7:0] alu_a;
	logic [7:0] alu_b;
	logic [7:0] alu_result;
	logic alu_carry;
	logic alu_half_carry;
	logic alu_zero;
	logic [5:0] pin_in;
	logic [5:0] pin_dir_input;
	logic [5:0] pin_latch;
	logic readback_latch;
	logic [5:0] pin_level;
	logic [5:0] pin_readback;

	modport alu_side(input alu_kind, alu_a, alu_b,
		output alu_result, alu_carry, alu_half_carry, alu_zero);
	modport pin_side(input pin_in, pin_dir_input, pin_latch, readback_latch,
		output pin_level, pin_readback);
	modport bank_side(output alu_kind, alu_a, alu_b, pin_in, pin_dir_input,
		pin_latch, readback_latch,
		input alu_result, alu_carry, alu_half_carry, alu_zero, pin_level, pin_readback);
endinterface

// ==== sfr_flag_alu.sv ====
`timescale 1ns/1ps
module sfr_flag_alu (
	sfr_link_if.alu_side lnk
);
	logic [8:0] sum;
	logic [4:0] nib;

	always_comb begin
		sum = 9'h000;
		nib = 5'h00;
		lnk.alu_carry = 1'b0;
		lnk.alu_half_carry = 1'b0;
		lnk.alu_result = lnk.alu_a;
		unique case (lnk.alu_kind)
			core_sfr_pkg::ALU_ADD: begin
				sum = {1'b0, lnk.alu_a} + {1'b0, lnk.alu_b};
				nib = {1'b0, lnk.alu_a[3:0]} + {1'b0, lnk.alu_b[3:0]};
				lnk.alu_result = sum[7:0];
				lnk.alu_carry = sum[8];
				lnk.alu_half_carry = nib[4];
			end
			core_sfr_pkg::ALU_SUB: begin
				sum = {1'b0, lnk.alu_a} - {1'b0, lnk.alu_b};
				nib = {1'b0, lnk.alu_a[3:0]} - {1'b0, lnk.alu_b[3:0]};
				lnk.alu_result = sum[7:0];
				lnk.alu_carry = ~sum[8];
				lnk.alu_half_carry = ~nib[4];
			end
			core_sfr_pkg::ALU_LOGIC: begin
				// Logic result is formed by the core and passed in on alu_a
				lnk.alu_result = lnk.alu_a;
			end
			default: begin
				lnk.alu_result = lnk.alu_a;
			end
		endcase
		lnk.alu_zero = (lnk.alu_result == 8'h00);
	end
endmodule

// ==== sfr_port_pins.sv ====
`timescale 1ns/1ps
`include "core_sfr_defs.svh"
module sfr_port_pins (
	input wire logic clk,
	input wire logic rst_b,
	sfr_link_if.pin_side lnk
);
	logic [`PORT_PINS-1:0] meta_q;
	logic [`PORT_PINS-1:0] sync_q;

	genvar i;
	generate
		for (i = 0; i < `PORT_PINS; i = i + 1) begin : g_pin
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= lnk.pin_in[i];
					sync_q[i] <= meta_q[i];
				end
			end
			// Inputs read the pin; outputs read pin or latch by option
			assign lnk.pin_readback[i] = (lnk.pin_dir_input[i] || !lnk.readback_latch) ?
				sync_q[i] : lnk.pin_latch[i];
		end
	endgenerate

	assign lnk.pin_level = sync_q;
endmodule

// ==== core_sfr_port_control_bank.sv ====
`timescale 1ns/1ps
`include "core_sfr_defs.svh"
// Operation
// - Carry set on add carry or no borrow
// - Half carry from bit four likewise
// - Zero flag follows the result of every ALU operation being zero
// - Power-down flag: up on clear, down on sleep
// - Timeout flag: up on clear/sleep, down on timeout
// - Pointer low six bits select indirect register
// - Pointer bank bits ignored in decoding
// - Port read: pin, or latch by option
// - Port write updates six output latches
// - Power bit 3 enables low-voltage reset
// - Power bit 6 makes pin zero interrupt
// - Power bit 7 enables the watchdog
// - Wake-up bits enable wake per pin
// - Buffer low bits hold counter bits 9:8
// - Pull-down bits active low, pins 0-3
// - Pull-up bits active low, pins 0-5
// - Enable bit 0 gates timer0 overflow interrupt
// - Spare general bits are plain storage
// - Short call loads buffer bits, pushes return
// - All banks map onto bank zero registers
module core_sfr_port_control_bank (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	output logic rd_hit,
	output logic [5:0] gpr_wr_addr,
	output logic [5:0] gpr_rd_addr,
	input wire logic alu_valid,
	input wire core_sfr_pkg::alu_kind_type alu_kind,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	output logic [7:0] alu_result,
	input wire logic clrwdt_exec,
	input wire logic sleep_exec,
	input wire logic wdt_timeout,
	input wire logic call_exec,
	input wire logic [7:0] call_target,
	input wire logic [9:0] pc_now,
	output logic call_pc_load,
	output logic [9:0] call_pc,
	output logic [9:0] call_push_addr,
	input wire logic [5:0] pin_in,
	input wire logic [5:0] pin_dir_input,
	input wire logic readback_source_option,
	output logic [5:0] port_out_latch,
	output logic [5:0] port_pin_level,
	output logic ext_irq_in,
	output logic [5:0] pin_wakeup_enable,
	output logic [3:0] pulldown_enable_n,
	output logic [5:0] pullup_enable_n,
	output logic low_voltage_reset_enable,
	output logic ext_irq_pin_select,
	output logic watchdog_enable,
	output logic timer0_overflow_irq_enable,
	output logic [7:0] irq_enable,
	output logic carry_flag,
	output logic half_carry_flag,
	output logic zero_flag,
	output logic power_down_flag_n,
	output logic timeout_flag_n
);
	sfr_link_if lnk ();

	logic [7:0] status_q;
	logic [7:0] indirect_pointer_q;
	logic [7:0] port_data_q;
	logic [7:0] power_control_q;
	logic [7:0] pin_wakeup_enable_q;
	logic [7:0] counter_high_buffer_q;
	logic [7:0] pin_pulldown_control_q;
	logic [7:0] pin_pullup_control_q;
	logic [7:0] irq_enable_q;
	logic [7:0] rd_data_q;
	logic rd_hit_q;
	logic [7:0] rd_data_d;
	logic rd_hit_d;
	logic call_pc_load_q;
	logic [9:0] call_pc_q;
	logic [9:0] call_push_addr_q;
	logic [7:0] alu_result_q;
	logic [5:0] wr_eff;
	logic [5:0] rd_eff;
	logic wr_sfr;
	logic [3:0] wr_ofs;
	logic [3:0] rd_ofs;

	// Bank bits dropped; address zero redirects through the pointer
	assign wr_eff = (wr_addr[5:0] == 6'h00) ? indirect_pointer_q[5:0] : wr_addr[5:0];
	assign rd_eff = (rd_addr[5:0] == 6'h00) ? indirect_pointer_q[5:0] : rd_addr[5:0];
	assign gpr_wr_addr = wr_eff;
	assign gpr_rd_addr = rd_eff;
	assign wr_sfr = wr_en && (wr_eff[5:4] == 2'b00);
	assign wr_ofs = wr_eff[3:0];
	assign rd_ofs = rd_eff[3:0];

	assign lnk.alu_kind = alu_kind;
	assign lnk.alu_a = alu_a;
	assign lnk.alu_b = alu_b;
	assign lnk.pin_in = pin_in;
	assign lnk.pin_dir_input = pin_dir_input;
	assign lnk.pin_latch = port_data_q[5:0];
	assign lnk.readback_latch = readback_source_option;

	sfr_flag_alu u_alu (
		.lnk(lnk.alu_side)
	);

	sfr_port_pins u_pins (
		.clk(clk),
		.rst_b(rst_b),
		.lnk(lnk.pin_side)
	);

	// Status: software write, then arithmetic flags, then reset-cause events
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			status_q <= `SFR_RST_STATUS;
		end else begin
			if (wr_sfr && wr_ofs == `SFR_OFS_STATUS) begin
				status_q <= wr_data;
			end
			if (alu_valid) begin
				if (alu_kind != core_sfr_pkg::ALU_LOGIC) begin
					status_q[`ST_CARRY] <= lnk.alu_carry;
					status_q[`ST_HALF_CARRY] <= lnk.alu_half_carry;
				end
				status_q[`ST_ZERO] <= lnk.alu_zero;
			end
			if (clrwdt_exec) begin
				status_q[`ST_POWER_DOWN_N] <= 1'b1;
			end else if (sleep_exec) begin
				status_q[`ST_POWER_DOWN_N] <= 1'b0;
			end
			// A timeout in the same cycle as a clear still lands
			if (wdt_timeout) begin
				status_q[`ST_TIMEOUT_N] <= 1'b0;
			end else if (clrwdt_exec || sleep_exec) begin
				status_q[`ST_TIMEOUT_N] <= 1'b1;
			end
		end
	end

	// Pointer keeps all eight bits; only the low six are decoded
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			indirect_pointer_q <= `SFR_RST_POINTER;
		end else if (wr_sfr && wr_ofs == `SFR_OFS_POINTER) begin
			indirect_pointer_q <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			port_data_q <= `SFR_RST_PORT;
		end else if (wr_sfr && wr_ofs == `SFR_OFS_PORT) begin
			port_data_q <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			power_control_q <= `SFR_RST_POWER;
		end else if (wr_sfr && wr_ofs == `SFR_OFS_POWER) begin
			power_control_q <= wr_data;
		end
	end

	// Masked writes keep unimplemented bits at their fixed level
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pin_wakeup_enable_q <= `SFR_RST_WAKEUP;
		end else if (wr_sfr && wr_ofs == `SFR_OFS_WAKEUP) begin
			pin_wakeup_enable_q <= wr_data & `SFR_MASK_WAKEUP;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			counter_high_buffer_q <= `SFR_RST_COUNTER_HIGH_BUFFER;
		end else if (wr_sfr && wr_ofs == `SFR_OFS_COUNTER_HIGH_BUFFER) begin
			counter_high_buffer_q <= wr_data & `SFR_MASK_COUNTER_HIGH_BUFFER;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pin_pulldown_control_q <= `SFR_RST_PULLDOWN;
		end else if (wr_sfr && wr_ofs == `SFR_OFS_PULLDOWN) begin
			pin_pulldown_control_q <= (wr_data & `SFR_MASK_PULLDOWN) |
				`SFR_FILL_PULLDOWN;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pin_pullup_control_q <= `SFR_RST_PULLUP;
		end else if (wr_sfr && wr_ofs == `SFR_OFS_PULLUP) begin
			pin_pullup_control_q <= wr_data & `SFR_MASK_PULLUP;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_enable_q <= `SFR_RST_IRQ_EN;
		end else if (wr_sfr && wr_ofs == `SFR_OFS_IRQ_EN) begin
			irq_enable_q <= wr_data & `SFR_MASK_IRQ_EN;
		end
	end

	// Read mux; unmapped offsets and general registers answer zero here
	always_comb begin
		rd_data_d = 8'h00;
		rd_hit_d = (rd_eff[5:4] == 2'b00);
		if (rd_eff[5:4] == 2'b00) begin
			unique case (rd_ofs)
				`SFR_OFS_STATUS: rd_data_d = status_q;
				`SFR_OFS_POINTER: rd_data_d = indirect_pointer_q;
				`SFR_OFS_PORT: rd_data_d = {port_data_q[7:6], lnk.pin_readback};
				`SFR_OFS_POWER: rd_data_d = power_control_q;
				`SFR_OFS_WAKEUP: rd_data_d = pin_wakeup_enable_q;
				`SFR_OFS_COUNTER_HIGH_BUFFER: rd_data_d = counter_high_buffer_q;
				`SFR_OFS_PULLDOWN: rd_data_d = pin_pulldown_control_q;
				`SFR_OFS_PULLUP: rd_data_d = pin_pullup_control_q;
				`SFR_OFS_IRQ_EN: rd_data_d = irq_enable_q;
				default: begin
					rd_data_d = 8'h00;
					rd_hit_d = 1'b0;
				end
			endcase
		end
	end

	// Read data stand until the next read strobe
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rd_data_q <= 8'h00;
			rd_hit_q <= 1'b0;
		end else if (rd_en) begin
			rd_data_q <= rd_data_d;
			rd_hit_q <= rd_hit_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			alu_result_q <= 8'h00;
		end else if (alu_valid) begin
			alu_result_q <= lnk.alu_result;
		end
	end

	// Short call: target low byte, high bits from buffer, return pushed
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			call_pc_load_q <= 1'b0;
			call_pc_q <= 10'h000;
			call_push_addr_q <= 10'h000;
		end else begin
			call_pc_load_q <= call_exec;
			if (call_exec) begin
				call_pc_q <= {counter_high_buffer_q[1:0], call_target};
				call_push_addr_q <= pc_now + 10'h001;
			end
		end
	end

	// Outputs come straight from register bits; ext_irq_in gates synced pin zero with power bit 6
	assign rd_data = rd_data_q;
	assign rd_hit = rd_hit_q;
	assign alu_result = alu_result_q;
	assign call_pc_load = call_pc_load_q;
	assign call_pc = call_pc_q;
	assign call_push_addr = call_push_addr_q;
	assign port_out_latch = port_data_q[5:0];
	assign port_pin_level = lnk.pin_level;
	assign ext_irq_in = power_control_q[`PWR_EXT_IRQ_SEL] & lnk.pin_level[0];
	assign ext_irq_pin_select = power_control_q[`PWR_EXT_IRQ_SEL];
	assign low_voltage_reset_enable = power_control_q[`PWR_LVR_EN];
	assign watchdog_enable = power_control_q[`PWR_WDT_EN];
	assign pin_wakeup_enable = pin_wakeup_enable_q[5:0];
	assign pulldown_enable_n = pin_pulldown_control_q[`PULLDOWN_LSB +: `PULLDOWN_PINS];
	assign pullup_enable_n = pin_pullup_control_q[5:0];
	assign timer0_overflow_irq_enable = irq_enable_q[`IRQ_TIMER0];
	assign irq_enable = irq_enable_q;
	assign carry_flag = status_q[`ST_CARRY];
	assign half_carry_flag = status_q[`ST_HALF_CARRY];
	assign zero_flag = status_q[`ST_ZERO];
	assign power_down_flag_n = status_q[`ST_POWER_DOWN_N];
	assign timeout_flag_n = status_q[`ST_TIMEOUT_N];
endmodule

// ==== core_pin_model.sv ====
`timescale 1ns/1ps
// Input pins follow the outside world and output pins follow the latch; a fault
// overloads the output pins so that they read opposite to the latch
module core_pin_model (
	input wire logic [5:0] latch,
	input wire logic [5:0] dir_input,
	input wire logic [5:0] ext,
	input wire logic fault,
	output logic [5:0] pins
);
	assign pins = (dir_input & ext) | (~dir_input & (fault ? ~latch : latch));
endmodule

// ==== core_sfr_bank_sva.sv ====
`timescale 1ns/1ps
module core_sfr_bank_sva (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic alu_valid,
	input wire core_sfr_pkg::alu_kind_type alu_kind,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic clrwdt_exec,
	input wire logic sleep_exec,
	input wire logic wdt_timeout,
	input wire logic call_exec,
	input wire logic [7:0] call_target,
	input wire logic [9:0] pc_now,
	input wire logic call_pc_load,
	input wire logic [9:0] call_pc,
	input wire logic [9:0] call_push_addr,
	input wire logic [5:0] pin_in,
	input wire logic [5:0] port_pin_level,
	input wire logic low_voltage_reset_enable,
	input wire logic ext_irq_pin_select,
	input wire logic watchdog_enable,
	input wire logic carry_flag,
	input wire logic half_carry_flag,
	input wire logic zero_flag,
	input wire logic power_down_flag_n,
	input wire logic timeout_flag_n
);
	logic is_sub;
	logic exp_c;
	logic exp_h;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	assign is_sub = alu_kind == core_sfr_pkg::ALU_SUB;
	assign exp_c = is_sub ? alu_a >= alu_b : (9'h000 + alu_a + alu_b) > 9'h0FF;
	assign exp_h = is_sub ? alu_a[3:0] >= alu_b[3:0] : (5'h00 + alu_a[3:0] + alu_b[3:0]) > 5'h0F;
	a_carry_flag: assert property (
		alu_valid && alu_kind != core_sfr_pkg::ALU_LOGIC |=> carry_flag == $past(exp_c))
		else $error("carry flag wrong");
	a_half_flag: assert property (
		alu_valid && alu_kind != core_sfr_pkg::ALU_LOGIC |=> half_carry_flag == $past(exp_h))
		else $error("half carry flag wrong");
	a_zero_flag: assert property (
		alu_valid && alu_kind == core_sfr_pkg::ALU_LOGIC |=> zero_flag == ($past(alu_a) == 8'h00))
		else $error("zero flag wrong");
	a_sleep_flag: assert property (sleep_exec && !clrwdt_exec |=> !power_down_flag_n)
		else $error("power down flag not cleared");
	a_clear_flags: assert property (
		clrwdt_exec && !wdt_timeout |=> power_down_flag_n && timeout_flag_n)
		else $error("flags not set by watchdog clear");
	a_timeout_flag: assert property (wdt_timeout |=> !timeout_flag_n)
		else $error("timeout flag not cleared");
	a_call_target: assert property (call_exec |=> call_pc_load &&
		call_pc[7:0] == $past(call_target) && call_push_addr == $past(pc_now) + 10'h001)
		else $error("call outputs wrong");
	a_call_pulse: assert property (!call_exec |=> !call_pc_load)
		else $error("call load without call");
	a_pin_sync: assert property (
		rst_b && $past(rst_b) && $past(rst_b, 2) |-> port_pin_level == $past(pin_in, 2))
		else $error("pin level not two cycles behind");
	a_power_write: assert property (wr_en && wr_addr[5:0] == 6'h08 |=>
		($past(wr_data) & 8'hC8) == {watchdog_enable, ext_irq_pin_select, 2'b00,
		low_voltage_reset_enable, 3'b000})
		else $error("power control outputs wrong");
	c_sub: cover property (alu_valid && is_sub);
	c_call: cover property (call_exec);
	c_sleep: cover property (sleep_exec && wdt_timeout);
endmodule
bind core_sfr_port_control_bank core_sfr_bank_sva chk (.*);

// ==== test_core_sfr_port_control_bank.sv ====
`timescale 1ns/1ps
module test_core_sfr_port_control_bank;
	logic clk, rst_b, wr_en, rd_en, rd_hit, alu_valid, clrwdt_exec, sleep_exec, wdt_timeout;
	logic call_exec, call_pc_load, readback_source_option, ext_irq_in, pin_fault;
	logic low_voltage_reset_enable, ext_irq_pin_select, watchdog_enable;
	logic timer0_overflow_irq_enable, carry_flag, half_carry_flag, zero_flag;
	logic power_down_flag_n, timeout_flag_n;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data, alu_a, alu_b, alu_result, call_target;
	logic [7:0] irq_enable;
	logic [5:0] gpr_wr_addr, gpr_rd_addr, pin_in, pin_dir_input, port_out_latch, pin_ext;
	logic [5:0] port_pin_level, pin_wakeup_enable, pullup_enable_n;
	logic [3:0] pulldown_enable_n;
	logic [9:0] pc_now, call_pc, call_push_addr;
	core_sfr_pkg::alu_kind_type alu_kind;
	int num_errors;
	int check_count;
	logic [7:0] ra [8] = '{8'h03, 8'h04, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E};
	logic [7:0] rv [8] = '{8'h18, 8'h00, 8'h88, 8'h3F, 8'h00, 8'hFF, 8'h3F, 8'h00};
	logic [7:0] ma [6] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h03};
	logic [7:0] mf [6] = '{8'h3F, 8'h07, 8'hFF, 8'h3F, 8'h4F, 8'hFF};
	logic [7:0] mz [6] = '{8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00};

	core_sfr_port_control_bank uut (.*);
	core_pin_model pins (.latch(port_out_latch), .dir_input(pin_dir_input), .ext(pin_ext),
		.fault(pin_fault), .pins(pin_in));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task summarize;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [9:0] g, input logic [9:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge clk);
		wr_en = 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		rd_en = 1'b1;
		rd_addr = a;
		@(negedge clk);
		rd_en = 1'b0;
		chk(rd_data, e);
	endtask

	task alu(input core_sfr_pkg::alu_kind_type k, input logic [7:0] a, input logic [7:0] b,
		input logic [2:0] e);
		@(negedge clk);
		alu_valid = 1'b1;
		alu_kind = k;
		alu_a = a;
		alu_b = b;
		@(negedge clk);
		alu_valid = 1'b0;
		chk({carry_flag, half_carry_flag, zero_flag}, e);
	endtask

	task ev(input logic [2:0] v, input logic [1:0] e);
		@(negedge clk);
		{clrwdt_exec, sleep_exec, wdt_timeout} = v;
		@(negedge clk);
		{clrwdt_exec, sleep_exec, wdt_timeout} = 3'b000;
		chk({power_down_flag_n, timeout_flag_n}, e);
	endtask

	initial begin
		#100000;
		num_errors++;
		summarize;
	end

	initial begin
		num_errors = 0;
		check_count = 0;
		{rst_b, wr_en, rd_en, alu_valid, clrwdt_exec, sleep_exec, wdt_timeout, call_exec} = 8'h00;
		{wr_addr, wr_data, rd_addr, alu_a, alu_b, call_target} = 48'h0;
		alu_kind = core_sfr_pkg::ALU_ADD;
		pc_now = 10'h000;
		pin_dir_input = 6'h0F;
		pin_ext = 6'h05;
		pin_fault = 1'b0;
		readback_source_option = 1'b0;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
		for (int i = 0; i < 6; i++) begin
			wr(ma[i], 8'hFF);
			rd(ma[i], mf[i]);
		end
		chk({pin_wakeup_enable, pulldown_enable_n}, 10'h3FF);
		chk({timer0_overflow_irq_enable, pullup_enable_n}, 10'h07F);
		chk(irq_enable, 10'h04F);
		for (int i = 0; i < 6; i++) begin
			wr(ma[i], 8'h00);
			rd(ma[i], mz[i]);
		end
		chk({pullup_enable_n, pulldown_enable_n}, 10'h000);
		alu(core_sfr_pkg::ALU_ADD, 8'hFF, 8'h01, 3'b111);
		alu(core_sfr_pkg::ALU_ADD, 8'h08, 8'h08, 3'b010);
		alu(core_sfr_pkg::ALU_SUB, 8'h05, 8'h05, 3'b111);
		alu(core_sfr_pkg::ALU_SUB, 8'h03, 8'h05, 3'b000);
		alu(core_sfr_pkg::ALU_SUB, 8'h10, 8'h01, 3'b100);
		chk(alu_result, 10'h00F);
		alu(core_sfr_pkg::ALU_LOGIC, 8'h00, 8'h00, 3'b101);
		alu(core_sfr_pkg::ALU_LOGIC, 8'h5A, 8'h00, 3'b100);
		chk(alu_result, 10'h05A);
		ev(3'b100, 2'b11);
		ev(3'b010, 2'b01);
		ev(3'b001, 2'b00);
		ev(3'b011, 2'b00);
		ev(3'b110, 2'b11);
		ev(3'b101, 2'b10);
		wr(8'h04, 8'hC8);
		wr(8'h00, 8'h5A);
		chk(gpr_wr_addr, 10'h008);
		rd(8'h48, 8'h5A);
		chk(rd_hit, 10'h001);
		chk(gpr_rd_addr, 10'h008);
		chk({ext_irq_in, watchdog_enable, low_voltage_reset_enable}, 10'h005);
		wr(8'h08, 8'hB7);
		chk({ext_irq_pin_select, ext_irq_in}, 10'h000);
		chk({watchdog_enable, low_voltage_reset_enable}, 10'h002);
		rd(8'h08, 8'hB7);
		wr(8'h05, 8'hFF);
		rd(8'h05, 8'h00);
		chk(rd_hit, 10'h000);
		wr(8'h06, 8'hEA);
		chk(port_out_latch, 10'h02A);
		repeat (2) @(negedge clk);
		rd(8'h06, 8'hE5);
		pin_fault = 1'b1;
		repeat (2) @(negedge clk);
		rd(8'h06, 8'hD5);
		readback_source_option = 1'b1;
		rd(8'h06, 8'hE5);
		wr(8'h0A, 8'h02);
		@(negedge clk);
		call_exec = 1'b1;
		call_target = 8'h12;
		pc_now = 10'h3FF;
		@(negedge clk);
		call_exec = 1'b0;
		chk(call_pc, 10'h212);
		chk(call_push_addr, 10'h000);
		chk(call_pc_load, 10'h001);
		@(negedge clk);
		chk(call_pc_load, 10'h000);
		summarize;
	end
endmodule
